// >>> rtl/dlrw_core.sv
// Direct byte load and ROM word lookup execution unit with register bus
// What this block does
// [RL1] Short direct load: 84H page 00, 85H page 01, 83H page FE; else long.
// [RL2] Direct load copies addressed byte into accumulator; PC advances by length.
// [RL3] Direct loads copy a present ninth source bit into status word bit 1.
// [RL4] Long direct load 86H, low then high address byte, three bytes, two cycles.
// [RL5] Lookup opcode 88H; second byte 0, six-bit index, C-select bit.
// [RL6] Every lookup variant is two bytes, four cycles, PC plus two.
// [RL7] Lookup address is 17 bits: nine from odd register, eight from even.
// [RL8] Lookup reads program memory in the bank chosen by the bank flag.
// [RL9] C variant adds C register as signed eight-bit value.
// [RL10] Displacement variant uses pointer zero plus signed seven-bit offset.
// [RL11] Software keeps pointer index below 63.
// [RL12] Lookup puts addressed byte in A, next byte in B; flags untouched.
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module dlrw_core (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        instr_valid,
    input  wire dlrw_pkg::dlrw_instr_s       instr,
    output logic                             instr_ready,
    output logic                             done,
    output logic [15:0]                      dmem_addr,
    output logic                             dmem_rd,
    input  wire dlrw_pkg::dlrw_dmem_s        dmem_rsp,
    output logic [dlrw_pkg::ROM_AW-1:0]      rom_addr,
    output logic                             rom_bank,
    output logic                             rom_rd,
    input  wire logic [7:0]                  rom_rdata,
    input  wire logic [4:0]                  avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [31:0]                 avs_writedata,
    output logic [31:0]                      avs_readdata,
    output logic                             avs_waitrequest
);
    dlrw_pkg::dlrw_state_e          state_ff;
    logic                           ready_ff;
    logic                           done_ff;
    logic [15:0]                    dmem_addr_ff;
    logic                           dmem_rd_ff;
    logic [dlrw_pkg::ROM_AW-1:0]    rom_addr_ff;
    logic                           rom_rd_ff;
    logic                           bank_ff;
    logic [7:0]                     acc_ff;
    logic [7:0]                     breg_ff;
    logic [7:0]                     creg_ff;
    logic                           ninth_flag_ff;
    logic [dlrw_pkg::PC_W-1:0]      pc_ff;
    logic                           badop_ff;
    logic [7:0]                     ptr_lo_ff;
    logic                           use_disp_ff;
    logic                           use_creg_ff;
    logic [6:0]                     disp_ff;
    logic [1:0]                     len_ff;
    logic [dlrw_pkg::PC_W-1:0]      pc_start_ff;
    logic                           accept;
    logic                           is_short;
    logic                           is_long;
    logic                           is_lookup;
    logic                           sw_wr;
    logic [31:0]                    rd_value;
    logic [dlrw_pkg::ROM_AW-1:0]    nxt_rom_addr;
    logic [15:0]                    short_addr;
    logic [15:0]                    ptr_addr;

    assign accept    = instr_valid && ready_ff;
    assign is_short  = (instr.op == dlrw_pkg::OP_DIR_ZERO) || (instr.op == dlrw_pkg::OP_DIR_ONE)
                    || (instr.op == dlrw_pkg::OP_DIR_TOP);
    assign is_long   = (instr.op == dlrw_pkg::OP_DIR_LONG);
    assign is_lookup = (instr.op == dlrw_pkg::OP_LOOKUP);

    // Page byte chosen by the opcode, low byte from the operand
    always_comb begin
        short_addr = {dlrw_pkg::PAGE_TOP, instr.b1}; // RL1
        if (instr.op == dlrw_pkg::OP_DIR_ZERO) begin
            short_addr = {dlrw_pkg::PAGE_ZERO, instr.b1}; // RL1
        end else if (instr.op == dlrw_pkg::OP_DIR_ONE) begin
            short_addr = {dlrw_pkg::PAGE_ONE, instr.b1}; // RL1
        end
    end

    // Even register of the selected pair; displacement form always uses pair zero
    always_comb begin
        ptr_addr = 16'h0000; // RL10
        if (!instr.b1[dlrw_pkg::MODE_BIT]) begin
            ptr_addr = {9'h000, instr.b1[6:1], 1'b0}; // RL5 RL11
        end
    end

    // Sum of the pointer pair and the offset of the variant in use
    dlrw_addr_calc u_addr (
        .ptr_hi   (dmem_rsp.data),
        .ptr_lo   (ptr_lo_ff),
        .use_disp (use_disp_ff),
        .use_creg (use_creg_ff),
        .disp     (disp_ff),
        .creg     (creg_ff),
        .rom_addr (nxt_rom_addr)
    );

    // Sequencer; the number of states per branch sets the required cycle count
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= dlrw_pkg::ST_IDLE;
            ready_ff <= 1'b1;
            done_ff  <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            case (state_ff)
                dlrw_pkg::ST_IDLE: begin
                    if (accept && is_short) begin
                        state_ff <= dlrw_pkg::ST_DRD; // RL1
                        ready_ff <= 1'b0;
                    end else if (accept && is_long) begin
                        state_ff <= dlrw_pkg::ST_LWAIT; // RL4
                        ready_ff <= 1'b0;
                    end else if (accept && is_lookup) begin
                        state_ff <= dlrw_pkg::ST_PLO; // RL6
                        ready_ff <= 1'b0;
                    end
                end
                dlrw_pkg::ST_LWAIT: state_ff <= dlrw_pkg::ST_DRD;
                dlrw_pkg::ST_PLO:   state_ff <= dlrw_pkg::ST_PHI;
                dlrw_pkg::ST_PHI:   state_ff <= dlrw_pkg::ST_RLO;
                dlrw_pkg::ST_RLO:   state_ff <= dlrw_pkg::ST_RHI;
                dlrw_pkg::ST_DRD, dlrw_pkg::ST_RHI: begin
                    state_ff <= dlrw_pkg::ST_IDLE;
                    ready_ff <= 1'b1;
                    done_ff  <= 1'b1;
                end
                default: begin
                    state_ff <= dlrw_pkg::ST_IDLE;
                    ready_ff <= 1'b1;
                end
            endcase
        end
    end

    // Captures the decoded variant and length for the later cycles
    always_ff @(posedge clk) begin
        if (rst) begin
            use_disp_ff <= 1'b0;
            use_creg_ff <= 1'b0;
            disp_ff     <= 7'h00;
            len_ff      <= 2'h0;
            pc_start_ff <= dlrw_pkg::RST_PC;
        end else if (accept) begin
            use_disp_ff <= instr.b1[dlrw_pkg::MODE_BIT]; // RL10
            use_creg_ff <= instr.b1[dlrw_pkg::CREG_BIT]; // RL5
            disp_ff     <= instr.b1[6:0];
            len_ff      <= is_long ? dlrw_pkg::LEN_LONG
                         : is_lookup ? dlrw_pkg::LEN_LOOKUP : dlrw_pkg::LEN_SHORT;
            pc_start_ff <= pc_ff;
        end
    end

    // Data memory address: operand, or the two registers of the pointer pair
    always_ff @(posedge clk) begin
        if (rst) begin
            dmem_addr_ff <= 16'h0000;
            dmem_rd_ff   <= 1'b0;
        end else if (state_ff == dlrw_pkg::ST_IDLE && accept && is_short) begin
            dmem_addr_ff <= short_addr; // RL1
            dmem_rd_ff   <= 1'b1;
        end else if (state_ff == dlrw_pkg::ST_IDLE && accept && is_long) begin
            dmem_addr_ff <= {instr.b2, instr.b1}; // RL4
            dmem_rd_ff   <= 1'b0;
        end else if (state_ff == dlrw_pkg::ST_IDLE && accept && is_lookup) begin
            dmem_addr_ff <= ptr_addr; // RL7
            dmem_rd_ff   <= 1'b1;
        end else if (state_ff == dlrw_pkg::ST_LWAIT) begin
            dmem_rd_ff   <= 1'b1; // Second cycle of the long form
        end else if (state_ff == dlrw_pkg::ST_PLO) begin
            dmem_addr_ff <= dmem_addr_ff + 16'h0001; // RL7
        end else if (state_ff == dlrw_pkg::ST_PHI || state_ff == dlrw_pkg::ST_DRD) begin
            dmem_rd_ff   <= 1'b0;
        end
    end

    // Low pointer byte held until the high byte arrives
    always_ff @(posedge clk) begin
        if (rst) begin
            ptr_lo_ff <= 8'h00;
        end else if (state_ff == dlrw_pkg::ST_PLO) begin
            ptr_lo_ff <= dmem_rsp.data[7:0]; // RL7
        end
    end

    // ROM address pair and the bank it is read from
    always_ff @(posedge clk) begin
        if (rst) begin
            rom_addr_ff <= '0;
            rom_rd_ff   <= 1'b0;
        end else if (state_ff == dlrw_pkg::ST_PHI) begin
            rom_addr_ff <= nxt_rom_addr; // RL9
            rom_rd_ff   <= 1'b1;
        end else if (state_ff == dlrw_pkg::ST_RLO) begin
            rom_addr_ff <= rom_addr_ff + 17'h00001; // RL12
        end else if (state_ff == dlrw_pkg::ST_RHI) begin
            rom_rd_ff   <= 1'b0;
        end
    end

    // Bank flag is software owned; bank output follows it
    always_ff @(posedge clk) begin
        if (rst) begin
            bank_ff <= 1'b0;
        end else if (sw_wr && avs_address == dlrw_pkg::REG_CTRL) begin
            bank_ff <= avs_writedata[dlrw_pkg::CTRL_BANK]; // RL8
        end
    end

    // Accumulator and B; execution wins over a software write in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_ff  <= dlrw_pkg::RST_BYTE;
            breg_ff <= dlrw_pkg::RST_BYTE;
        end else if (state_ff == dlrw_pkg::ST_DRD) begin
            acc_ff  <= dmem_rsp.data[7:0]; // RL2
        end else if (state_ff == dlrw_pkg::ST_RLO) begin
            acc_ff  <= rom_rdata; // RL12
        end else if (state_ff == dlrw_pkg::ST_RHI) begin
            breg_ff <= rom_rdata; // RL12
        end else if (sw_wr && avs_address == dlrw_pkg::REG_BA) begin
            acc_ff  <= avs_writedata[7:0];
            breg_ff <= avs_writedata[15:8];
        end
    end

    // C register, the signed offset source
    always_ff @(posedge clk) begin
        if (rst) begin
            creg_ff <= dlrw_pkg::RST_BYTE;
        end else if (sw_wr && avs_address == dlrw_pkg::REG_CREG) begin
            creg_ff <= avs_writedata[7:0];
        end
    end

    // Ninth bit moves on direct loads from a source that has one, and on a software write to the flags register
    always_ff @(posedge clk) begin
        if (rst) begin
            ninth_flag_ff <= 1'b0;
        end else if (state_ff == dlrw_pkg::ST_DRD && dmem_rsp.has9) begin
            ninth_flag_ff <= dmem_rsp.data[8]; // RL3
        end else if (sw_wr && avs_address == dlrw_pkg::REG_FLAGS) begin
            ninth_flag_ff <= avs_writedata[dlrw_pkg::FLAGS_NINTH];
        end
    end

    // Program counter steps by the instruction length at completion
    always_ff @(posedge clk) begin
        if (rst) begin
            pc_ff <= dlrw_pkg::RST_PC;
        end else if (state_ff == dlrw_pkg::ST_DRD || state_ff == dlrw_pkg::ST_RHI) begin
            pc_ff <= pc_ff + {15'h0000, len_ff}; // RL2 RL6
        end else if (sw_wr && avs_address == dlrw_pkg::REG_PC) begin
            pc_ff <= avs_writedata[dlrw_pkg::PC_W-1:0];
        end
    end

    // Unknown opcode is consumed and flagged; set wins over a clearing write
    always_ff @(posedge clk) begin
        if (rst) begin
            badop_ff <= 1'b0;
        end else if (accept && !is_short && !is_long && !is_lookup) begin
            badop_ff <= 1'b1;
        end else if (sw_wr && avs_address == dlrw_pkg::REG_STATUS
                     && avs_writedata[dlrw_pkg::STAT_BADOP]) begin
            badop_ff <= 1'b0;
        end
    end

    // Read mux; unmapped offsets read as zero
    always_comb begin
        rd_value = 32'h00000000;
        if (avs_address == dlrw_pkg::REG_CTRL) begin
            rd_value[dlrw_pkg::CTRL_BANK] = bank_ff;
        end else if (avs_address == dlrw_pkg::REG_BA) begin
            rd_value[15:0] = {breg_ff, acc_ff};
        end else if (avs_address == dlrw_pkg::REG_PC) begin
            rd_value[dlrw_pkg::PC_W-1:0] = pc_ff;
        end else if (avs_address == dlrw_pkg::REG_FLAGS) begin
            rd_value[dlrw_pkg::FLAGS_NINTH] = ninth_flag_ff;
        end else if (avs_address == dlrw_pkg::REG_STATUS) begin
            rd_value[dlrw_pkg::STAT_BUSY]  = !ready_ff;
            rd_value[dlrw_pkg::STAT_BADOP] = badop_ff;
        end else if (avs_address == dlrw_pkg::REG_CREG) begin
            rd_value[7:0] = creg_ff;
        end
    end

    dlrw_bus_slave u_bus (
        .clk         (clk),
        .rst         (rst),
        .read        (avs_read),
        .write       (avs_write),
        .rd_value    (rd_value),
        .waitrequest (avs_waitrequest),
        .readdata    (avs_readdata),
        .wr_en       (sw_wr)
    );

    assign instr_ready = ready_ff;
    assign done        = done_ff;
    assign dmem_addr   = dmem_addr_ff;
    assign dmem_rd     = dmem_rd_ff;
    assign rom_addr    = rom_addr_ff;
    assign rom_bank    = bank_ff;
    assign rom_rd      = rom_rd_ff;

    // Checks on timing and data paths
    short_lat_a: assert property (@(posedge clk) disable iff (rst) // RL1
        accept && is_short |=> done_ff == 1'b0 ##1 done_ff)
        else $error("short direct load did not finish in one cycle");
    long_lat_a: assert property (@(posedge clk) disable iff (rst) // RL4
        accept && is_long |=> !done_ff[*2] ##1 done_ff)
        else $error("long direct load did not finish in two cycles");
    lookup_lat_a: assert property (@(posedge clk) disable iff (rst) // RL6
        accept && is_lookup |=> !done_ff[*4] ##1 done_ff)
        else $error("rom word lookup did not finish in four cycles");
    pc_step_a: assert property (@(posedge clk) disable iff (rst) // RL2
        done_ff |-> pc_ff == pc_start_ff + {15'h0000, len_ff})
        else $error("program counter did not advance by instruction length");
    page_one_a: assert property (@(posedge clk) disable iff (rst) // RL1
        accept && instr.op == dlrw_pkg::OP_DIR_ONE
        |=> dmem_addr_ff == {dlrw_pkg::PAGE_ONE, $past(instr.b1)})
        else $error("short page one address wrong");
    ninth_bit_a: assert property (@(posedge clk) disable iff (rst) // RL3
        state_ff == dlrw_pkg::ST_DRD && dmem_rsp.has9
        |=> ninth_flag_ff == $past(dmem_rsp.data[8]))
        else $error("ninth bit not copied to status word");
    rom_pair_a: assert property (@(posedge clk) disable iff (rst) // RL12
        state_ff == dlrw_pkg::ST_RLO |=> rom_addr_ff == $past(rom_addr_ff) + 17'h00001
                                         && acc_ff == $past(rom_rdata))
        else $error("lookup byte pair not sequential");
    rom_bank_a: assert property (@(posedge clk) disable iff (rst) // RL8
        sw_wr && avs_address == dlrw_pkg::REG_CTRL
        |=> rom_bank == $past(avs_writedata[dlrw_pkg::CTRL_BANK]))
        else $error("lookup bank does not follow bank flag");
    lookup_flags_a: assert property (@(posedge clk) disable iff (rst) // RL12
        state_ff == dlrw_pkg::ST_PLO ##1 !sw_wr[*4] |-> $stable(ninth_flag_ff))
        else $error("lookup changed status word");
    ptr_index_a: assert property (@(posedge clk) disable iff (rst) // RL5
        accept && is_lookup && !instr.b1[7] |=> dmem_addr_ff == {9'h000, $past(instr.b1[6:1]), 1'b0}
                                                ##1 dmem_addr_ff[0])
        else $error("pointer pair address wrong");
    disp_base_a: assert property (@(posedge clk) disable iff (rst) // RL10
        accept && is_lookup && instr.b1[7] |=> dmem_addr_ff == 16'h0000)
        else $error("displacement form not based on pointer zero");
endmodule : dlrw_core

// >>> shared/dlrw_pkg.sv
// Shared constants and carrier types for the direct load and ROM word lookup unit
package dlrw_pkg;
    // Opcodes of the handled instructions
    localparam logic [7:0] OP_DIR_ZERO = 8'h84;
    localparam logic [7:0] OP_DIR_ONE  = 8'h85;
    localparam logic [7:0] OP_DIR_TOP  = 8'h83;
    localparam logic [7:0] OP_DIR_LONG = 8'h86;
    localparam logic [7:0] OP_LOOKUP   = 8'h88;
    // Page bytes of the short direct forms
    localparam logic [7:0] PAGE_ZERO   = 8'h00;
    localparam logic [7:0] PAGE_ONE    = 8'h01;
    localparam logic [7:0] PAGE_TOP    = 8'hFE;
    // Instruction lengths in bytes
    localparam logic [1:0] LEN_SHORT   = 2'h2;
    localparam logic [1:0] LEN_LONG    = 2'h3;
    localparam logic [1:0] LEN_LOOKUP  = 2'h2;
    // Second byte fields of the lookup form
    localparam int         MODE_BIT    = 7;
    localparam int         CREG_BIT    = 0;
    // Widths
    localparam int         ROM_AW      = 17;
    localparam int         PC_W        = 17;
    // Register byte offsets on the bus
    localparam logic [4:0] REG_CTRL    = 5'h00;
    localparam logic [4:0] REG_BA      = 5'h04;
    localparam logic [4:0] REG_PC      = 5'h08;
    localparam logic [4:0] REG_FLAGS   = 5'h0C;
    localparam logic [4:0] REG_STATUS  = 5'h10;
    localparam logic [4:0] REG_CREG    = 5'h14;
    // Field positions
    localparam int         CTRL_BANK   = 0;
    localparam int         FLAGS_NINTH = 1;
    localparam int         STAT_BUSY   = 0;
    localparam int         STAT_BADOP  = 1;
    // Reset values
    localparam logic [7:0]      RST_BYTE = 8'h00;
    localparam logic [PC_W-1:0] RST_PC   = 17'h00000;

    // Instruction bytes as delivered by the fetch stage
    typedef struct packed {
        logic [7:0] op;
        logic [7:0] b1;
        logic [7:0] b2;
    } dlrw_instr_s;

    // Data memory answer: byte plus optional ninth bit
    typedef struct packed {
        logic       has9;
        logic [8:0] data;
    } dlrw_dmem_s;

    // Execution states
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_LWAIT = 7'h02,
        ST_DRD   = 7'h04,
        ST_PLO   = 7'h08,
        ST_PHI   = 7'h10,
        ST_RLO   = 7'h20,
        ST_RHI   = 7'h40
    } dlrw_state_e;
endpackage : dlrw_pkg

// >>> rtl/dlrw_addr_calc.sv
// ROM lookup address former: pointer pair plus signed offset
`timescale 1ns/1ps
module dlrw_addr_calc (
    input  wire logic [8:0]                  ptr_hi,
    input  wire logic [7:0]                  ptr_lo,
    input  wire logic                        use_disp,
    input  wire logic                        use_creg,
    input  wire logic [6:0]                  disp,
    input  wire logic [7:0]                  creg,
    output logic      [dlrw_pkg::ROM_AW-1:0] rom_addr
);
    logic [dlrw_pkg::ROM_AW-1:0] offset;

    // Sign extend whichever offset the variant asks for
    always_comb begin
        offset = '0;
        if (use_disp) begin
            offset = {{10{disp[6]}}, disp}; // RL10
        end else if (use_creg) begin
            offset = {{9{creg[7]}}, creg}; // RL9
        end
    end

    // Upper nine bits from the odd register, low eight from the even one
    assign rom_addr = {ptr_hi, ptr_lo} + offset; // RL7
endmodule : dlrw_addr_calc

// >>> rtl/dlrw_bus_slave.sv
// Avalon-MM handshake: one wait cycle, then a single-cycle answer
`timescale 1ns/1ps
module dlrw_bus_slave (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] rd_value,
    output logic             waitrequest,
    output logic [31:0]      readdata,
    output logic             wr_en
);
    logic        wait_ff;
    logic [31:0] rdata_ff;

    // Drops waitrequest for exactly one cycle per request
    always_ff @(posedge clk) begin
        if (rst) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= !((read || write) && wait_ff);
        end
    end

    // Read data sampled while waiting, stands during the answer cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= 32'h00000000;
        end else if (read && wait_ff) begin
            rdata_ff <= rd_value;
        end
    end

    assign waitrequest = wait_ff;
    assign readdata    = rdata_ff;
    assign wr_en       = write && !wait_ff; // Write lands on the answer edge
endmodule : dlrw_bus_slave

// >>> tb/dlrw_core_test.sv
// Self-checking bench for the direct load and ROM word lookup unit
`timescale 1ns/1ps
module dlrw_core_test;
    logic                  clk, rst, instr_valid, avs_read, avs_write, r_bk, r_got, p_e;
    logic                  instr_ready, done, dmem_rd, rom_bank, rom_rd, avs_waitrequest;
    logic [15:0]           dmem_addr, d_seen;
    logic [16:0]           rom_addr, r_seen, pc_e;
    logic [7:0]            rom_rdata, a_e, b_e;
    logic [4:0]            avs_address;
    logic [31:0]           avs_writedata, avs_readdata, q;
    logic [8:0]            pm [0:127];
    int                    failures = 0;
    int                    n_compared = 0;
    dlrw_pkg::dlrw_instr_s instr;
    dlrw_pkg::dlrw_dmem_s  dmem_rsp;

    // Data memory: low 128 bytes from a table, the rest a pattern; odd bytes carry a ninth bit
    function automatic logic [9:0] dm(input logic [15:0] a);
        logic [8:0] d;
        d = (a < 16'h0080) ? pm[a[6:0]] : {a[2], a[7:0] ^ a[15:8]};
        return {a[0], d};
    endfunction : dm
    // Program memory pattern mixes the bank in, so a wrong bank shows up
    function automatic logic [7:0] rf(input logic bk, input logic [16:0] a);
        return a[7:0] ^ {a[16:10], bk};
    endfunction : rf

    assign dmem_rsp  = dm(dmem_addr);
    assign rom_rdata = rf(rom_bank, rom_addr);

    dlrw_core dlrw_core_i (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .instr_ready(instr_ready), .done(done), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
        .dmem_rsp(dmem_rsp), .rom_addr(rom_addr), .rom_bank(rom_bank), .rom_rd(rom_rd),
        .rom_rdata(rom_rdata), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    task automatic test_done;
        if (failures == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Avalon transfer: request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int i;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (i == 20) begin
            chk("bus_timeout", 0, 1);
            test_done();
        end
        @(posedge clk);
    endtask : bus

    // One instruction; valid dropped after the take edge so it is not taken twice
    task automatic exec(input logic [7:0] op, b1, b2, input int lat);
        int i;
        r_got = 1'b0;
        instr <= '{op, b1, b2};
        instr_valid <= 1'b1;
        for (i = 0; i < 10; i++) begin
            @(posedge clk);
            if (instr_ready === 1'b1) break;
        end
        instr_valid <= 1'b0;
        if (i == 10) begin
            chk("ready_timeout", 0, 1);
            test_done();
        end
        for (i = 1; i < 9; i++) begin
            @(posedge clk);
            if (dmem_rd === 1'b1) d_seen = dmem_addr;
            if (rom_rd === 1'b1 && !r_got) begin
                r_seen = rom_addr;
                r_bk = rom_bank;
                r_got = 1'b1;
            end
            if (done === 1'b1) break;
            chk("instr_ready", {31'h0, lat == 0}, {31'h0, instr_ready});
        end
        chk("latency", (lat == 0) ? 9 : lat + 1, i);
    endtask : exec

    task automatic chk_regs;
        bus(1'b0, dlrw_pkg::REG_BA, 32'h0);
        chk("ba", {16'h0, b_e, a_e}, {16'h0, q[15:0]});
        bus(1'b0, dlrw_pkg::REG_PC, 32'h0);
        chk("pc", {15'h0, pc_e}, {15'h0, q[16:0]});
        bus(1'b0, dlrw_pkg::REG_FLAGS, 32'h0);
        chk("ninth_flag", {31'h0, p_e}, {31'h0, q[dlrw_pkg::FLAGS_NINTH]});
    endtask : chk_regs

    // Every register, and two unmapped places, read zero after reset
    task automatic t_reset;
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 5'(i * 4), 32'h0);
            chk("reset_reg", 32'h0, q);
        end
    endtask : t_reset

    // Short forms on each page, long form inside and outside the short ranges
    task automatic t_direct;
        logic [7:0] ops [6] = '{8'h84, 8'h85, 8'h83, 8'h86, 8'h86, 8'h86};
        logic [7:0] lo [6] = '{8'h11, 8'hFF, 8'h00, 8'h10, 8'h05, 8'h11};
        logic [7:0] hi [6] = '{8'h00, 8'h01, 8'hFE, 8'h02, 8'hFF, 8'h00};
        logic [9:0] e;
        for (int i = 0; i < 6; i++) begin
            exec(ops[i], lo[i], hi[i], (ops[i] == 8'h86) ? 2 : 1);
            e = dm({hi[i], lo[i]});
            a_e = e[7:0];
            if (e[9]) p_e = e[8];
            pc_e = pc_e + ((ops[i] == 8'h86) ? 17'h3 : 17'h2);
            chk("dmem_addr", {16'h0, hi[i], lo[i]}, {16'h0, d_seen});
            chk_regs();
        end
    endtask : t_direct

    // Plain, C-offset and displacement lookups at offset extremes, both banks
    task automatic t_lookup;
        logic [7:0]  b1 [7] = '{8'h04, 8'h05, 8'h05, 8'hFE, 8'hBF, 8'hC0, 8'h7D};
        logic [7:0]  cr [7] = '{8'h00, 8'hFE, 8'h7F, 8'h00, 8'h00, 8'h00, 8'h80};
        logic [16:0] ad [7] = '{17'h0013E, 17'h0013C, 17'h001BD, 17'h000FE, 17'h0013F,
                                17'h000C0, 17'h1FF7F};
        logic        bk;
        bus(1'b1, dlrw_pkg::REG_FLAGS, 32'h2);
        p_e = 1'b1;
        for (int i = 0; i < 7; i++) begin
            bk = i[0];
            bus(1'b1, dlrw_pkg::REG_CREG, {24'h0, cr[i]});
            bus(1'b1, dlrw_pkg::REG_CTRL, {31'h0, bk});
            exec(8'h88, b1[i], 8'h00, 4);
            a_e = rf(bk, ad[i]);
            b_e = rf(bk, ad[i] + 17'h1);
            pc_e = pc_e + 17'h2;
            chk("rom_addr", {15'h0, ad[i]}, {15'h0, r_seen});
            chk("rom_bank", {31'h0, bk}, {31'h0, r_bk});
            chk_regs();
        end
    endtask : t_lookup

    // Unknown opcode is flagged, not executed; unmapped write is dropped
    task automatic t_badop;
        exec(8'h00, 8'h00, 8'h00, 0);
        chk("ready", 32'h1, {31'h0, instr_ready});
        bus(1'b0, dlrw_pkg::REG_STATUS, 32'h0);
        chk("status", 32'h2, q);
        bus(1'b1, dlrw_pkg::REG_STATUS, 32'h2);
        bus(1'b1, 5'h18, 32'hFFFFFFFF);
        bus(1'b0, dlrw_pkg::REG_STATUS, 32'h0);
        chk("status_clr", 32'h0, q);
        bus(1'b0, 5'h18, 32'h0);
        chk("unmapped", 32'h0, q);
        chk_regs();
    endtask : t_badop

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Main sequence; pointer pairs 0, 2 and 62 set up in the table
    initial begin
        {rst, instr_valid, avs_read, avs_write, p_e} = 5'h10;
        {instr, avs_address, avs_writedata, pc_e, a_e, b_e} = '0;
        for (int i = 0; i < 128; i++) pm[i] = {i[1], i[7:0] ^ 8'h5A};
        {pm[0], pm[1], pm[4], pm[5]} = {9'h000, 9'h001, 9'h03E, 9'h001};
        {pm[124], pm[125]} = {9'h0FF, 9'h1FF};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_direct();
        t_lookup();
        t_badop();
        test_done();
    end
endmodule : dlrw_core_test
